/* design/pin_driver.sv */
`timescale 1ns/1ps
`include "pin_gpio_defines.svh"

module pin_driver #(
    parameter int PINS = 8
) (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic [PINS-1:0] enable_bits,
    input  wire logic [PINS-1:0] value_bits,
    input  wire logic            boundary_scan_active,
    input  wire logic            clock_pin_clock_gate,
    input  wire logic            clock_source,
    output logic      [PINS-1:0] pin_out,
    output logic      [PINS-1:0] pin_oe
);
    logic [PINS-1:0] eff_en;

    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            if (i <= `SCAN_PIN_MSB) begin : g_scan
                assign eff_en[i] = enable_bits[i] & ~boundary_scan_active;
            end else begin : g_plain
                assign eff_en[i] = enable_bits[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_oe  <= eff_en;
            pin_out <= value_bits;
            if (!eff_en[`BIT_CLOCK_PIN]) begin
                pin_oe[`BIT_CLOCK_PIN]  <= clock_pin_clock_gate;
                pin_out[`BIT_CLOCK_PIN] <= clock_source & clock_pin_clock_gate;
            end
        end
    end

    pin_oe_a: assert property (@(posedge clk) disable iff (sys_rst)
        !eff_en[0] |=> !pin_oe[0]) else $error("oe without enable");
    clk_gpio_a: assert property (@(posedge clk) disable iff (sys_rst)
        eff_en[6] |=> pin_out[6] == $past(value_bits[6])) else $error("clock not off");
    scan_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
        boundary_scan_active |=> pin_oe[3:0] == 4'h0) else $error("scan pin driven");
    scan_cov: cover property (@(posedge clk) boundary_scan_active && enable_bits[0]);
endmodule

/* design/pin_gpio_and_signal_monitor.sv */
// Contract
// - output-enable register at 0x44, one bit per pin, set makes pin gpio
// - clock pin enable set turns clock function off, pin becomes gpio
// - boundary scan active makes enables of bits 3 to 0 ineffective
// - output-value register at 0x45 feeds the eight output buffers
// - read-only register 0x46 returns current input levels of pins
// - bit 7 of 0x47 selects fast pad switching, raising peak current
// - selector 0h or 1h leaves signal output pin high impedance
// - selector 2h drives low, 3h drives high
// - selector 4h transmit envelope, 5h transmitter active
// - selector 6h routes secure channel serial signal
// - selector 7h routes receive envelope, valid only at 106 kBd
// - selector 8h receiver active, 9h received bit stream
// - clock gate control gates clock on pin when not gpio
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "pin_gpio_defines.svh"

module pin_gpio_and_signal_monitor #(
    parameter int PINS = 8
) (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic [7:0]      addr,
    input  wire logic [7:0]      wdata,
    input  wire logic            wr_strobe,
    input  wire logic            rd_strobe,
    output logic      [7:0]      rdata,
    input  wire logic [PINS-1:0] pin_in,
    output logic      [PINS-1:0] pin_out,
    output logic      [PINS-1:0] pin_oe,
    output logic                 signal_output_pin_out,
    output logic                 signal_output_pin_oe,
    output logic                 fast_pad_switching,
    input  wire logic            boundary_scan_active,
    input  wire logic            clock_pin_clock_gate,
    input  wire logic            clock_source,
    input  wire logic            tx_envelope,
    input  wire logic            tx_active,
    input  wire logic            secure_channel_serial_signal,
    input  wire logic            rx_envelope,
    input  wire logic            rx_active,
    input  wire logic            rx_bits
);
    logic [PINS-1:0] pin_output_enable_reg;
    logic [PINS-1:0] pin_output_value_reg;
    logic [PINS-1:0] pin_input_level_reg;
    logic            fast_pad_reg;
    logic [3:0]      selector_reg;
    logic [7:0]      rdata_next;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_output_enable_reg <= PINS'(`RST_PIN_OUTPUT_ENABLE);
        end else if (wr_strobe && addr == `ADDR_PIN_OUTPUT_ENABLE) begin
            pin_output_enable_reg <= wdata[PINS-1:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_output_value_reg <= PINS'(`RST_PIN_OUTPUT_VALUE);
        end else if (wr_strobe && addr == `ADDR_PIN_OUTPUT_VALUE) begin
            pin_output_value_reg <= wdata[PINS-1:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fast_pad_reg <= 1'b0;
            selector_reg <= 4'h0;
        end else if (wr_strobe && addr == `ADDR_SIGNAL_OUTPUT_SELECT) begin
            fast_pad_reg <= wdata[`BIT_FAST_PAD_SWITCHING];
            selector_reg <= wdata[`SEL_FIELD_MSB:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_input_level_reg <= '0;
        end else begin
            pin_input_level_reg <= pin_in;
        end
    end

    // pad speed drives from a flop, only one consumer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fast_pad_switching <= 1'b0;
        end else begin
            fast_pad_switching <= fast_pad_reg;
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        if (addr == `ADDR_PIN_OUTPUT_ENABLE) begin
            rdata_next = 8'(pin_output_enable_reg);
        end else if (addr == `ADDR_PIN_OUTPUT_VALUE) begin
            rdata_next = 8'(pin_output_value_reg);
        end else if (addr == `ADDR_PIN_INPUT_LEVEL) begin
            rdata_next = 8'(pin_input_level_reg);
        end else if (addr == `ADDR_SIGNAL_OUTPUT_SELECT) begin
            rdata_next = {fast_pad_reg, 3'h0, selector_reg};
        end
    end

    // read data valid only the cycle after the strobe, else zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (rd_strobe) begin
            rdata <= rdata_next;
        end else begin
            rdata <= 8'h00;
        end
    end

    pin_driver #(
        .PINS (PINS)
    ) u_pin_driver (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .enable_bits          (pin_output_enable_reg),
        .value_bits           (pin_output_value_reg),
        .boundary_scan_active (boundary_scan_active),
        .clock_pin_clock_gate (clock_pin_clock_gate),
        .clock_source         (clock_source),
        .pin_out              (pin_out),
        .pin_oe               (pin_oe)
    );

    signal_mux u_signal_mux (
        .clk                          (clk),
        .sys_rst                      (sys_rst),
        .output_selector_field        (selector_reg),
        .tx_envelope                  (tx_envelope),
        .tx_active                    (tx_active),
        .secure_channel_serial_signal (secure_channel_serial_signal),
        .rx_envelope                  (rx_envelope),
        .rx_active                    (rx_active),
        .rx_bits                      (rx_bits),
        .sig_out                      (signal_output_pin_out),
        .sig_oe                       (signal_output_pin_oe)
    );

    en_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_strobe && addr == 8'h44 |=> pin_output_enable_reg == $past(wdata))
        else $error("enable not written");
    val_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_strobe && addr == 8'h45 |=> pin_output_value_reg == $past(wdata))
        else $error("value not written");
    in_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        rd_strobe && addr == 8'h46 |=> rdata == $past(pin_input_level_reg))
        else $error("input readback wrong");
    pad_speed_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_strobe && addr == 8'h47 |=> ##1 fast_pad_switching == $past(wdata[7], 2))
        else $error("pad speed wrong");
    rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        rd_strobe && addr == 8'h47 |=> rdata[6:4] == 3'h0)
        else $error("reserved not zero");
    clk_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !pin_output_enable_reg[6] && !clock_pin_clock_gate |=> !pin_out[6])
        else $error("clock not gated");
    pin_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
        pin_output_enable_reg[7] |=> pin_oe[7] && pin_out[7] == $past(pin_output_value_reg[7]))
        else $error("pin not driven");
    gpio_cov: cover property (@(posedge clk) wr_strobe && addr == 8'h44 ##1 rd_strobe);
endmodule

/* design/signal_mux.sv */
`timescale 1ns/1ps

module signal_mux (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] output_selector_field,
    input  wire logic       tx_envelope,
    input  wire logic       tx_active,
    input  wire logic       secure_channel_serial_signal,
    input  wire logic       rx_envelope,
    input  wire logic       rx_active,
    input  wire logic       rx_bits,
    output logic            sig_out,
    output logic            sig_oe
);
    logic out_next;
    logic oe_next;

    always_comb begin
        out_next = 1'b0;
        oe_next  = 1'b1;
        case (output_selector_field)
            pin_gpio_pkg::SEL_LOW:       out_next = 1'b0;
            pin_gpio_pkg::SEL_HIGH:      out_next = 1'b1;
            pin_gpio_pkg::SEL_TX_ENV:    out_next = tx_envelope;
            pin_gpio_pkg::SEL_TX_ACTIVE: out_next = tx_active;
            pin_gpio_pkg::SEL_SECURE:    out_next = secure_channel_serial_signal;
            pin_gpio_pkg::SEL_RX_ENV:    out_next = rx_envelope;
            pin_gpio_pkg::SEL_RX_ACTIVE: out_next = rx_active;
            pin_gpio_pkg::SEL_RX_BITS:   out_next = rx_bits;
            default:                     oe_next  = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sig_out <= 1'b0;
            sig_oe  <= 1'b0;
        end else begin
            sig_out <= out_next;
            sig_oe  <= oe_next;
        end
    end

    sel_hiz_a: assert property (@(posedge clk) disable iff (sys_rst)
        (output_selector_field <= 4'h1) |=> !sig_oe) else $error("pin driven");
    sel_const_a: assert property (@(posedge clk) disable iff (sys_rst)
        (output_selector_field == 4'h3) |=> sig_oe && sig_out) else $error("not high");
    sel_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        (output_selector_field == 4'h2) |=> sig_oe && !sig_out) else $error("not low");
    sel_tx_a: assert property (@(posedge clk) disable iff (sys_rst)
        (output_selector_field == 4'h4) |=> sig_out == $past(tx_envelope))
        else $error("tx env wrong");
    sel_sec_a: assert property (@(posedge clk) disable iff (sys_rst)
        (output_selector_field == 4'h6) |=> sig_out == $past(secure_channel_serial_signal))
        else $error("secure wrong");
    sel_rxenv_a: assert property (@(posedge clk) disable iff (sys_rst)
        (output_selector_field == 4'h7) |=> sig_out == $past(rx_envelope))
        else $error("rx env wrong");
    sel_rxbit_a: assert property (@(posedge clk) disable iff (sys_rst)
        (output_selector_field == 4'h9) |=> sig_oe && sig_out == $past(rx_bits))
        else $error("rx bits wrong");
    sel_rxact_a: assert property (@(posedge clk) disable iff (sys_rst)
        (output_selector_field == 4'h8) |=> sig_oe && sig_out == $past(rx_active))
        else $error("rx active wrong");
    sel_undef_a: assert property (@(posedge clk) disable iff (sys_rst)
        (output_selector_field >= 4'hA) |=> !sig_oe) else $error("undef driven");
    sel_low_cov: cover property (@(posedge clk) output_selector_field == 4'h2 ##1 sig_oe);
    sel_rx_cov: cover property (@(posedge clk) output_selector_field == 4'h8 ##1 sig_out);
endmodule

/* inc/pin_gpio_defines.svh */
`ifndef PIN_GPIO_DEFINES_SVH
`define PIN_GPIO_DEFINES_SVH

`define ADDR_PIN_OUTPUT_ENABLE    8'h44
`define ADDR_PIN_OUTPUT_VALUE     8'h45
`define ADDR_PIN_INPUT_LEVEL      8'h46
`define ADDR_SIGNAL_OUTPUT_SELECT 8'h47

`define RST_PIN_OUTPUT_ENABLE     8'h00
`define RST_PIN_OUTPUT_VALUE      8'h00
`define RST_SIGNAL_OUTPUT_SELECT  8'h00

`define BIT_FAST_PAD_SWITCHING    7
`define BIT_CLOCK_PIN             6
`define SEL_FIELD_MSB             3
`define SCAN_PIN_MSB              3

`endif

/* inc/pin_gpio_pkg.sv */
package pin_gpio_pkg;

    typedef enum logic [3:0] {
        SEL_HIZ_0      = 4'h0,
        SEL_HIZ_1      = 4'h1,
        SEL_LOW        = 4'h2,
        SEL_HIGH       = 4'h3,
        SEL_TX_ENV     = 4'h4,
        SEL_TX_ACTIVE  = 4'h5,
        SEL_SECURE     = 4'h6,
        SEL_RX_ENV     = 4'h7,
        SEL_RX_ACTIVE  = 4'h8,
        SEL_RX_BITS    = 4'h9
    } output_select_type;

endpackage

/* test/pin_gpio_and_signal_monitor_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module pin_gpio_and_signal_monitor_tb_top;
    logic        clk;
    logic        sys_rst;
    logic [7:0]  addr, wdata, rdata, pin_in, pin_out, pin_oe, ext_level;
    logic        wr_strobe, rd_strobe, sig_out, sig_oe, fast_pad, bs, gate, src;
    logic [5:0]  mon;
    logic [31:0] r;
    logic [7:0]  en, val, d, oe_e, out_e;
    int          fails, total_checks, cycles;
    int          seed = 41971;

    pin_gpio_and_signal_monitor #(.PINS(8)) uut (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .signal_output_pin_out(sig_out), .signal_output_pin_oe(sig_oe),
        .fast_pad_switching(fast_pad), .boundary_scan_active(bs),
        .clock_pin_clock_gate(gate), .clock_source(src),
        .tx_envelope(mon[0]), .tx_active(mon[1]), .secure_channel_serial_signal(mon[2]),
        .rx_envelope(mon[3]), .rx_active(mon[4]), .rx_bits(mon[5])
    );

    pin_world world (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_level(pin_in)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // generous ceiling, the full run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            close_out();
        end
    end

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask

    function automatic logic [7:0] exp_oe(logic [7:0] e, logic b, logic g);
        exp_oe = e;
        if (b) begin
            exp_oe[3:0] = 4'h0;
        end
        if (!e[6]) begin
            exp_oe[6] = g;
        end
    endfunction

    function automatic logic [1:0] exp_sig(logic [3:0] s, logic [5:0] m);
        case (s)
            4'h2: exp_sig = 2'b10;
            4'h3: exp_sig = 2'b11;
            4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9: exp_sig = {1'b1, m[s - 4'h4]};
            default: exp_sig = 2'b00;
        endcase
    endfunction

    initial begin
        sys_rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        bs = 1'b0;
        gate = 1'b0;
        src = 1'b0;
        mon = 6'h00;
        ext_level = 8'h5A;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        `CHK("oe_rst", 8'h00, pin_oe)
        chk_rd(8'h44, 8'h00);
        chk_rd(8'h47, 8'h00);
        reg_wr(8'h46, 8'hFF);
        reg_wr(8'h50, 8'hFF);
        chk_rd(8'h46, 8'h5A);
        chk_rd(8'h50, 8'h00);
        @(posedge clk);
        #1;
        `CHK("rd_idle", 8'h00, rdata)
        // random pin setups, first two are corners
        for (int k = 0; k < 24; k++) begin
            r = $random(seed);
            en = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : r[7:0];
            val = r[15:8];
            @(posedge clk);
            bs <= r[16] | (k == 0);
            gate <= r[17] | (k == 1);
            src <= r[18] | (k == 1);
            ext_level <= r[31:24];
            reg_wr(8'h44, en);
            reg_wr(8'h45, val);
            repeat (3) @(posedge clk);
            #1;
            oe_e = exp_oe(en, bs, gate);
            out_e = val;
            if (!en[6]) begin
                out_e[6] = src & gate;
            end
            `CHK("pin_oe", oe_e, pin_oe)
            `CHK("pin_out", out_e & oe_e, pin_out & oe_e)
            chk_rd(8'h44, en);
            chk_rd(8'h45, val);
            chk_rd(8'h46, (oe_e & out_e) | (~oe_e & ext_level));
        end
        for (int s = 0; s < 32; s++) begin
            r = $random(seed);
            d = {r[7:4], s[3:0]};
            @(posedge clk);
            mon <= r[13:8];
            reg_wr(8'h47, d);
            repeat (3) @(posedge clk);
            #1;
            `CHK("sig", exp_sig(d[3:0], mon), {sig_oe, sig_oe & sig_out})
            `CHK("pad", d[7], fast_pad)
            chk_rd(8'h47, d & 8'h8F);
        end
        // mid-run reset clears the registers again
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        `CHK("oe_rst2", 8'h00, pin_oe)
        `CHK("sig_rst", 2'b00, {sig_oe, sig_out})
        `CHK("pad_rst", 1'b0, fast_pad)
        chk_rd(8'h45, 8'h00);
        close_out();
    end
endmodule

/* test/pin_world.sv */
`timescale 1ns/1ps

module pin_world (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_level,
    output logic      [7:0] pin_level
);
    // outside drivers back off wherever the device drives, so no contention is modelled
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule
